// *** common/bus_freq_pkg.sv ***
package bus_freq_pkg;

  // Two-bit select codes; only one is defined, the rest are reserved
  localparam logic [1:0] CODE_100MHZ   = 2'h1;
  localparam logic [1:0] CODE_RSVD_00  = 2'h0;

  // Open-drain released value before the code is driven (pulled high)
  localparam logic [1:0] CODE_RELEASED = 2'h3;

  // Settling time of the decided code before power-good is honoured
  localparam int SETTLE_NS     = 200;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETTLE_COUNT = 4'(SETTLE_CYCLES);

  // Open-drain pin: output value and enable (enable low drives)
  typedef struct packed {
    logic [1:0] out_val;
    logic [1:0] oe_b;
  } sel_pin_t;

  // Request line zero pin group
  typedef struct packed {
    logic out_val;
    logic oe_b;
  } req_pin_t;

endpackage

// *** hdl/sync2.sv ***
`timescale 1ns/1ps

// Two-stage synchroniser for levels that arrive with no timing relation
module sync2 (
  input  wire logic clk,     // System clock
  input  wire logic rst_b,   // Async reset, active low
  input  wire logic d,       // Asynchronous level in
  output logic      q        // Synchronised level out
);

  logic meta;  // First stage, read only by the second stage

  // Plain two-flop chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// *** hdl/bus_freq_select.sv ***
`timescale 1ns/1ps


// The select code is decided inside the block and never changes. The pins
// stay released through reset, so the board pull-ups show a reserved value
// until the code is driven. Power-good is honoured only once the settle count
// is done. A partner that latches early sees the reserved value, never a
// half-driven code.
module bus_freq_select (
  input  wire logic                    clk,                     // 50 MHz clock
  input  wire logic                    rst_b,                   // Async reset, active low
  input  wire logic                    termination_power_good,  // Async power-good level
  input  wire logic                    bus_request_line_zero_in, // Request line zero in
  input  wire logic                    req_zero_drive,          // Core wants line zero low
  output bus_freq_pkg::sel_pin_t       bus_freq_select_code,    // Open-drain select pins
  output bus_freq_pkg::req_pin_t       bus_request_line_zero,   // Request line zero out
  output logic                         req_zero_seen,           // Line zero observed low
  output logic                         code_valid,              // Code settled and driven
  output logic                         freq_100mhz              // Decoded bus frequency
);

  //////////////////////////////////////////////////////////////////////////////
  // Power-good synchronisation

  logic pg_sync;  // Power-good after two flops

  // Power-good has no timing relation to clk, hence two flops
  // synchronise async inputs
  sync2 u_pg_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (termination_power_good),
    .q     (pg_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Frequency decision and settle state machine

  typedef enum logic [1:0] {
    ST_RELEASED,  // Pins released, value not guaranteed
    ST_SETTLE,    // Final code driven, counting settle time
    ST_VALID      // Code held until next reset
  } state_t;

  state_t     state;       // Present state
  state_t     next_state;  // Next state
  logic [3:0] settle_cnt;  // Settle cycles elapsed

  // Trade-off: the settle time is a fixed count, not measured, so a slow
  // board must lengthen the settle time in the package
  // device's own decision is fixed 100 MHz rating
  // operate only at the rated frequency
  wire logic [1:0] decided_code = bus_freq_pkg::CODE_100MHZ;
  wire logic       settle_done  = (settle_cnt == bus_freq_pkg::SETTLE_COUNT);

  // Next-state decode
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RELEASED: next_state = ST_SETTLE;
      ST_SETTLE:   if (settle_done) begin
        next_state = ST_VALID;
      end
      ST_VALID:    next_state = ST_VALID;
    endcase
  end

  // State and settle counter; code never leaves VALID without a reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ST_RELEASED;
      settle_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (state == ST_SETTLE && !settle_done) begin
        settle_cnt <= settle_cnt + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Select pin drive

  logic [1:0] code_reg;  // Code presented on the pins

  // pins released (read high) until the code is driven
  // once valid the code is frozen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      code_reg <= bus_freq_pkg::CODE_RELEASED;
    end else if (state != ST_RELEASED && state != ST_VALID) begin
      code_reg <= decided_code;
    end
  end

  // Bits that are one stay released and read high through the pull-up
  // Open drain: enable low only for zero bits while driving
  assign bus_freq_select_code.out_val = 2'h0;
  assign bus_freq_select_code.oe_b    = code_reg;

  assign freq_100mhz = (code_reg == bus_freq_pkg::CODE_100MHZ);

  // Valid falls again with power-good while the pins hold; a partner that
  // missed the rise must wait for the next power cycle
  // partners are told valid only after power-good and settle
  assign code_valid = (state == ST_VALID) && pg_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Request line zero

  logic req_in_q;  // Registered line level (bus-clock synchronous)

  // no interrupt-bus signal enters; none is sampled on clk
  // no test-port signal enters; the test clock stays apart
  // Reset value is the released level, so no false request after reset
  // sampled on the system clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_in_q <= 1'b1;
    end else begin
      req_in_q <= bus_request_line_zero_in;
    end
  end

  // only line zero is driven, open drain
  assign bus_request_line_zero.out_val = 1'b0;
  assign bus_request_line_zero.oe_b    = ~req_zero_drive;
  assign req_zero_seen                 = ~req_in_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Assertions check this block's outputs, state and settle counter against its inputs, its state and the package constants

  chk_code_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_VALID) |=> $stable(bus_freq_select_code.oe_b))
    else $error("select code changed after valid");

  chk_code_value: assert property (@(posedge clk) disable iff (!rst_b)
    code_valid |-> (bus_freq_select_code.oe_b == 2'h1) && freq_100mhz)
    else $error("valid code is not the 100 MHz code");

  chk_valid_needs_pg: assert property (@(posedge clk) disable iff (!rst_b)
    code_valid |-> $past(termination_power_good, 2))
    else $error("valid without power-good");

  chk_settle_len: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_SETTLE && $past(state) == ST_RELEASED) |->
      ##10 (state == ST_SETTLE) ##1 (state == ST_VALID))
    else $error("settle period wrong length");

  // code driven one cycle after entering the settle state
  chk_code_driven: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_SETTLE) |=> freq_100mhz)
    else $error("code not driven after decision");

  chk_req_drive: assert property (@(posedge clk) disable iff (!rst_b)
    bus_request_line_zero.oe_b == !req_zero_drive)
    else $error("request line zero drive mismatch");

  // sampled line lags pin by one cycle
  chk_req_sample: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 (req_zero_seen == !$past(bus_request_line_zero_in)))
    else $error("request line sample wrong");

  chk_pg_sync: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(termination_power_good) && state == ST_VALID ##1 termination_power_good
      |=> code_valid)
    else $error("power-good sync latency wrong");

  // pins released until the decision leaves reset state
  chk_pins_released: assert property (@(posedge clk) disable iff (!rst_b)
    (state == ST_RELEASED) |-> (bus_freq_select_code.oe_b == bus_freq_pkg::CODE_RELEASED))
    else $error("select pins driven before the decision");

  // a reserved all-zero code never reaches the pins
  chk_no_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    bus_freq_select_code.oe_b != bus_freq_pkg::CODE_RSVD_00)
    else $error("reserved select code on the pins");

  chk_od_low_only: assert property (@(posedge clk) disable iff (!rst_b)
    (bus_freq_select_code.out_val == 2'h0) && (bus_request_line_zero.out_val == 1'b0))
    else $error("open-drain pin driven high");

  // settle counter never passes its end point
  chk_settle_bound: assert property (@(posedge clk) disable iff (!rst_b)
    settle_cnt <= bus_freq_pkg::SETTLE_COUNT)
    else $error("settle counter overran");

  // valid drops two edges after power-good falls
  chk_valid_falls: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(termination_power_good) |=> ##1 !code_valid)
    else $error("valid outlived power-good");

  // decided code on the pins before valid is offered
  chk_valid_after_code: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(code_valid) |-> $past(freq_100mhz, 2))
    else $error("valid raised before the code settled");

endmodule

// *** dv/freq_latch_model.sv ***
`timescale 1ns/1ps

// Chipset side: resolves the pulled-up pins and latches the code
// scan order is board wiring; this model sits after the device
module freq_latch_model (
  input  wire logic                   clk,     // System clock
  input  wire logic                   por_b,   // Power-on reset, active low
  input  wire logic                   pg,      // Termination power-good
  input  wire bus_freq_pkg::sel_pin_t pins,    // Select pin drive
  output logic [1:0]                  pin_lvl, // Resolved pin level
  output logic [1:0]                  latched  // Captured code
);
  logic pg_d; // Power-good one edge ago

  // A released pin reads high through its pull-up
  assign pin_lvl = pins.oe_b | pins.out_val;

  // Capture on each power-good rise; a device reset must not recapture
  // a regulator latching its voltage code keeps the same rule
  always_ff @(posedge clk or negedge por_b) begin
    if (!por_b) begin
      pg_d    <= 1'b0;
      latched <= 2'h2;
    end else begin
      pg_d <= pg;
      if (pg && !pg_d) begin
        latched <= pin_lvl;
      end
    end
  end
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps

module testbench;
  logic clk, rst_b, por_b, pg, req_drv;   // Bench-driven inputs
  bus_freq_pkg::sel_pin_t sel;             // Select pin group
  bus_freq_pkg::req_pin_t req;             // Request line zero group
  logic seen, valid, f100;                 // Status outputs
  logic [1:0] lvl, latched;                // Model view
  int fail_count = 0;                      // Mismatches
  int n_compared = 0;                      // Comparisons
  wire line0 = req.oe_b ? 1'b1 : req.out_val; // Pulled-up wire

  bus_freq_select dut (.clk(clk), .rst_b(rst_b), .termination_power_good(pg),
    .bus_request_line_zero_in(line0), .req_zero_drive(req_drv),
    .bus_freq_select_code(sel), .bus_request_line_zero(req),
    .req_zero_seen(seen), .code_valid(valid), .freq_100mhz(f100));
  freq_latch_model far (.clk(clk), .por_b(por_b), .pg(pg), .pins(sel),
    .pin_lvl(lvl), .latched(latched));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Reset drive, then the decided code
  task automatic t_power_up;
    check(sel.oe_b, 2'h3);
    check({valid, f100}, 2'h0);
    @(posedge clk) rst_b <= 1'b1;
    tick(3);
    check(sel.oe_b, bus_freq_pkg::CODE_100MHZ);
    check(f100, 1'b1);
    tick(20);
    check(valid, 1'b0);
    check(latched, 2'h2);
  endtask

  // Power-good rise: partner latches a stable code
  task automatic t_valid;
    @(posedge clk) pg <= 1'b1;
    tick(3);
    check(valid, 1'b1);
    check(latched, bus_freq_pkg::CODE_100MHZ);
    for (int i = 0; i < 40; i++) begin
      tick(1);
      check(lvl, bus_freq_pkg::CODE_100MHZ);
    end
    @(posedge clk) pg <= 1'b0;
    tick(4);
    check(valid, 1'b0);
    check(sel.oe_b, bus_freq_pkg::CODE_100MHZ);
  endtask

  // Request line zero pulled and seen back
  task automatic t_req;
    @(posedge clk) req_drv <= 1'b1;
    tick(1);
    check({req.oe_b, req.out_val}, 2'h0);
    tick(2);
    check(seen, 1'b1);
    @(posedge clk) req_drv <= 1'b0;
    tick(3);
    check({seen, req.oe_b}, 2'h1);
  endtask

  // Power-good already high across a device reset
  task automatic t_early_pg;
    @(posedge clk) pg <= 1'b1;
    tick(3);
    check(latched, bus_freq_pkg::CODE_100MHZ);
    @(posedge clk) rst_b <= 1'b0;
    tick(2);
    check(sel.oe_b, 2'h3);
    @(posedge clk) rst_b <= 1'b1;
    tick(5);
    check(valid, 1'b0);
    tick(15);
    check(valid, 1'b1);
    check(latched, bus_freq_pkg::CODE_100MHZ);
  endtask

  // Hang guard: the tests need well under a thousand cycles
  initial begin
    #40000;
    fail_count++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0;
    por_b = 1'b0;
    pg = 1'b0;
    req_drv = 1'b0;
    tick(2);
    por_b <= 1'b1;
    t_power_up();
    t_valid();
    t_req();
    t_early_pg();
    give_verdict();
  end
endmodule
